// >>> ietu_core.sv
// interrupt controller with event transfer channels, routing unit and trap entry
// Functional notes
// - each node is served by a vectored interrupt or by a transfer channel
// - standard service ends in an entry pulse carrying the node's vector address
// - a channel service takes exactly one cycle of the cpu
// - a transfer moves a byte or word and bumps source, destination or both
// - each transfer counts the channel down by one, except in continuous mode
// - with the count at zero the next request goes to its own vector, except in continuous mode
// - eight channels, each with source, destination and count
// - entry comes 7 clocks after the request on a cache hit, 11 otherwise
// - 46 nodes, each with request flag, enable flag and priority
// - four shared nodes pick one of two sources by a select register
// - routing: four edge channels, a matrix, four output gates
// - edge channels detect rising, falling or both edges
// - gates forward routed events always, on pattern match or on miss
// - a trap branches to its handler like an interrupt, ahead of nodes
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module ietu_core
    import ietu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [AW-1:0]     reg_addr,
    input  wire logic [DW-1:0]     reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DW-1:0]     reg_rdata,
    input  wire logic [DED_NODES-1:0] periph_req,
    input  wire logic [2*SHR_N-1:0] shared_req,
    input  wire logic [RT_N-1:0]   ext_pin,
    input  wire logic [RT_N-1:0]   rt_periph,
    input  wire logic [TRAP_N-1:0] trap_req,
    input  wire logic [PRIO_W-1:0] cpu_level,
    input  wire logic              jump_cache_hit,
    output logic                   cpu_entry,
    output logic      [DW-1:0]     entry_vector,
    output logic                   entry_is_trap,
    output logic                   xfer_req,
    output logic      [DW-1:0]     xfer_src,
    output logic      [DW-1:0]     xfer_dst,
    output logic                   xfer_word,
    output logic      [CH_W-1:0]   xfer_chan,
    output logic                   irq
);
    logic [PRIO_W-1:0] prio_reg  [NODES];
    logic [CH_W-1:0]   chsel_reg [NODES];
    logic [NODES-1:0]  en_reg;
    logic [NODES-1:0]  req_reg;
    logic [NODES-1:0]  use_reg;
    logic [DW-1:0]     src_reg   [CHANS];
    logic [DW-1:0]     dst_reg   [CHANS];
    logic [CNT_W-1:0]  cnt_reg   [CHANS];
    logic [3:0]        cctl_reg  [CHANS];
    logic [SHR_N-1:0]  srcsel_reg;
    logic [11:0]       edge_reg;
    logic [DW-1:0]     route_reg;
    logic [RT_N-1:0]   trig_reg;
    logic [5:0]        gate_reg  [RT_N];
    logic [IRQ_W-1:0]  irq_st_reg;
    logic [IRQ_W-1:0]  irq_msk_reg;
    logic [TRAP_N-1:0] trap_reg;
    logic [RT_N-1:0]   pin_s1_reg;
    logic [RT_N-1:0]   pin_s2_reg;
    logic [3:0]        lat_reg;
    ietu_state_e       state_reg;

    logic [NODES-1:0]  node_src;
    logic [RT_N-1:0]   edge_ev;
    logic [RT_N-1:0]   gate_fire;
    logic [RT_N-1:0]   rt_level;
    logic              best_ok;
    logic [NODE_W-1:0] best_idx;
    logic [PRIO_W-1:0] best_prio;
    logic              trap_any;
    logic [1:0]        trap_idx;
    logic              grant;
    logic [CH_W-1:0]   sel_ch;
    logic              path_xfer;
    logic              xfer_go;
    logic              std_go;
    logic              trap_go;
    logic [DW-1:0]     step;
    logic              node_wr;
    logic              chan_wr;
    logic [CH_W-1:0]   wr_ch;
    logic [DW-1:0]     rdata_next;
    logic [IRQ_W-1:0]  irq_set;

    assign node_wr = reg_wr && (reg_addr < OFS_NODE_END);
    assign chan_wr = reg_wr && ((reg_addr & OFS_CHAN_MSK) == OFS_CHAN0);
    assign wr_ch   = reg_addr[4:2];

    // pins cross into the clock domain
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= ext_pin;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign rt_level = (edge_reg[EDGE_SEL_LSB +: RT_N] & rt_periph)
                    | (~edge_reg[EDGE_SEL_LSB +: RT_N] & pin_s2_reg);

    genvar gi;
    generate
        for (gi = 0; gi < RT_N; gi++) begin : g_rt
            ietu_edge_chan u_edge (
                .clk         (clk),
                .arst_n      (arst_n),
                .level       (rt_level[gi]),
                .mode        (edge_reg[2*gi +: 2]),
                .event_pulse (edge_ev[gi])
            );
            logic routed;
            logic match;
            assign routed = |(edge_ev & route_reg[4*gi +: 4]);
            assign match  = ((trig_reg ^ gate_reg[gi][3:0]) & route_reg[4*gi +: 4]) == 4'h0;
            always_comb begin
                case (ietu_gate_e'(gate_reg[gi][GC_MODE_LSB +: 2]))
                    GATE_ALL:   gate_fire[gi] = routed;
                    GATE_MATCH: gate_fire[gi] = routed & match;
                    GATE_MISS:  gate_fire[gi] = routed & ~match;
                    default:    gate_fire[gi] = 1'b0;
                endcase
            end
        end
        for (gi = 0; gi < SHR_N; gi++) begin : g_shr
            assign node_src[SHR_NODE0 + gi] = shared_req[2*gi + int'(srcsel_reg[gi])];
        end
    endgenerate

    assign node_src[DED_NODES-1:0]        = periph_req;
    assign node_src[GATE_NODE0 +: RT_N]   = gate_fire;

    always_comb begin
        best_ok   = 1'b0;
        best_idx  = '0;
        best_prio = '0;
        for (int n = 0; n < NODES; n++) begin
            if (req_reg[n] && en_reg[n] && (!best_ok || prio_reg[n] > best_prio)) begin
                best_ok   = 1'b1;
                best_idx  = NODE_W'(n);
                best_prio = prio_reg[n];
            end
        end
    end

    always_comb begin
        trap_idx = 2'h0;
        for (int t = TRAP_N - 1; t >= 0; t--) begin
            if (trap_reg[t]) begin
                trap_idx = 2'(t);
            end
        end
    end

    assign trap_any  = |trap_reg;
    assign trap_go   = (state_reg == ST_IDLE) && trap_any;
    assign grant     = (state_reg == ST_IDLE) && !trap_any && best_ok && (best_prio > cpu_level);
    assign sel_ch    = chsel_reg[best_idx];
    // empty channel falls back to the vector unless in continuous mode
    assign path_xfer = use_reg[best_idx]
                     && ((cnt_reg[sel_ch] != '0) || cctl_reg[sel_ch][CC_CONT]);
    assign xfer_go   = grant && path_xfer;
    assign std_go    = grant && !path_xfer;
    assign step      = cctl_reg[sel_ch][CC_WORD] ? WORD_STEP : BYTE_STEP;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_reg  <= '0;
            req_reg <= '0;
            use_reg <= '0;
            for (int n = 0; n < NODES; n++) begin
                prio_reg[n]  <= '0;
                chsel_reg[n] <= '0;
            end
        end else begin
            for (int n = 0; n < NODES; n++) begin
                if (node_wr && reg_addr[NODE_W-1:0] == NODE_W'(n)) begin
                    prio_reg[n]  <= reg_wdata[NC_PRIO_LSB +: PRIO_W];
                    en_reg[n]    <= reg_wdata[NC_EN];
                    use_reg[n]   <= reg_wdata[NC_USE];
                    chsel_reg[n] <= reg_wdata[NC_CH_LSB +: CH_W];
                    req_reg[n]   <= reg_wdata[NC_REQ] | node_src[n];
                end else begin
                    // event sets, service clears, set wins
                    req_reg[n] <= node_src[n] | (req_reg[n] & ~(grant && best_idx == NODE_W'(n)));
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < CHANS; c++) begin
                src_reg[c]  <= RST_WORD;
                dst_reg[c]  <= RST_WORD;
                cnt_reg[c]  <= '0;
                cctl_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < CHANS; c++) begin
                if (chan_wr && wr_ch == CH_W'(c)) begin
                    case (reg_addr[1:0])
                        CF_SRC:  src_reg[c]  <= reg_wdata;
                        CF_DST:  dst_reg[c]  <= reg_wdata;
                        CF_CNT:  cnt_reg[c]  <= reg_wdata[CNT_W-1:0];
                        default: cctl_reg[c] <= reg_wdata[3:0];
                    endcase
                end else if (xfer_go && sel_ch == CH_W'(c)) begin
                    if (cctl_reg[c][CC_INC_SRC]) begin
                        src_reg[c] <= src_reg[c] + step;
                    end
                    if (cctl_reg[c][CC_INC_DST]) begin
                        dst_reg[c] <= dst_reg[c] + step;
                    end
                    if (!cctl_reg[c][CC_CONT]) begin
                        cnt_reg[c] <= cnt_reg[c] - 8'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            xfer_req  <= 1'b0;
            xfer_src  <= RST_WORD;
            xfer_dst  <= RST_WORD;
            xfer_word <= 1'b0;
            xfer_chan <= '0;
        end else begin
            xfer_req <= xfer_go;
            if (xfer_go) begin
                xfer_src  <= src_reg[sel_ch];
                xfer_dst  <= dst_reg[sel_ch];
                xfer_word <= cctl_reg[sel_ch][CC_WORD];
                xfer_chan <= sel_ch;
            end
        end
    end

    // trap pending flags, a new trap wins over its clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trap_reg <= '0;
        end else begin
            trap_reg <= trap_req | (trap_reg & ~(trap_go ? (4'h1 << trap_idx) : 4'h0));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg     <= ST_IDLE;
            lat_reg       <= 4'h0;
            cpu_entry     <= 1'b0;
            entry_vector  <= RST_WORD;
            entry_is_trap <= 1'b0;
        end else begin
            cpu_entry <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (trap_go || std_go) begin
                        state_reg     <= ST_WAIT;
                        lat_reg       <= (jump_cache_hit ? LAT_HIT : LAT_MISS) - LAT_ADJ;
                        entry_is_trap <= trap_go;
                        entry_vector  <= trap_go
                            ? TRAP_VEC_BASE + (DW'(trap_idx) << VEC_SHIFT)
                            : NODE_VEC_BASE + (DW'(best_idx) << VEC_SHIFT);
                    end
                end
                ST_WAIT: begin
                    if (lat_reg == 4'h0) begin
                        state_reg <= ST_IDLE;
                        cpu_entry <= 1'b1;
                    end else begin
                        lat_reg <= lat_reg - 4'h1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // routing configuration and trigger flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            srcsel_reg <= '0;
            edge_reg   <= '0;
            route_reg  <= '0;
            trig_reg   <= '0;
            for (int g = 0; g < RT_N; g++) begin
                gate_reg[g] <= '0;
            end
        end else begin
            if (reg_wr && reg_addr == OFS_SRCSEL) begin
                srcsel_reg <= reg_wdata[SHR_N-1:0];
            end
            if (reg_wr && reg_addr == OFS_EDGE) begin
                edge_reg <= reg_wdata[11:0];
            end
            if (reg_wr && reg_addr == OFS_ROUTE) begin
                route_reg <= reg_wdata;
            end
            for (int g = 0; g < RT_N; g++) begin
                if (reg_wr && (reg_addr & OFS_GATE_MSK) == OFS_GATE0 && reg_addr[1:0] == 2'(g)) begin
                    gate_reg[g] <= reg_wdata[5:0];
                end
            end
            trig_reg <= edge_ev
                      | (trig_reg & ~((reg_wr && reg_addr == OFS_TRIG) ? reg_wdata[RT_N-1:0] : 4'h0));
        end
    end

    // interrupt status, set wins over write-one clear
    always_comb begin
        irq_set            = '0;
        irq_set[IRQ_TRAP]  = trap_go;
        irq_set[IRQ_CZERO] = std_go && use_reg[best_idx];
        irq_set[IRQ_GATE]  = |gate_fire;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_st_reg  <= '0;
            irq_msk_reg <= '0;
        end else begin
            irq_st_reg <= irq_set | (irq_st_reg
                        & ~((reg_wr && reg_addr == OFS_IRQ_ST) ? reg_wdata[IRQ_W-1:0] : 3'h0));
            if (reg_wr && reg_addr == OFS_IRQ_MSK) begin
                irq_msk_reg <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_st_reg & irq_msk_reg);

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_next = '0;
        if (reg_addr < OFS_NODE_END) begin
            rdata_next[NC_PRIO_LSB +: PRIO_W] = prio_reg[reg_addr[NODE_W-1:0]];
            rdata_next[NC_EN]                 = en_reg[reg_addr[NODE_W-1:0]];
            rdata_next[NC_REQ]                = req_reg[reg_addr[NODE_W-1:0]];
            rdata_next[NC_CH_LSB +: CH_W]     = chsel_reg[reg_addr[NODE_W-1:0]];
            rdata_next[NC_USE]                = use_reg[reg_addr[NODE_W-1:0]];
        end else if ((reg_addr & OFS_CHAN_MSK) == OFS_CHAN0) begin
            case (reg_addr[1:0])
                CF_SRC:  rdata_next = src_reg[wr_ch];
                CF_DST:  rdata_next = dst_reg[wr_ch];
                CF_CNT:  rdata_next[CNT_W-1:0] = cnt_reg[wr_ch];
                default: rdata_next[3:0] = cctl_reg[wr_ch];
            endcase
        end else if ((reg_addr & OFS_GATE_MSK) == OFS_GATE0) begin
            rdata_next[5:0] = gate_reg[reg_addr[1:0]];
        end else begin
            case (reg_addr)
                OFS_SRCSEL:  rdata_next[SHR_N-1:0] = srcsel_reg;
                OFS_EDGE:    rdata_next[11:0]      = edge_reg;
                OFS_ROUTE:   rdata_next            = route_reg;
                OFS_TRIG:    rdata_next[RT_N-1:0]  = trig_reg;
                OFS_IRQ_ST:  rdata_next[IRQ_W-1:0] = irq_st_reg;
                OFS_IRQ_MSK: rdata_next[IRQ_W-1:0] = irq_msk_reg;
                default:     rdata_next            = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= RST_WORD;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= RST_WORD;
        end
    end
endmodule : ietu_core

// >>> ietu_pkg.sv
// constants, encodings and register map of the interrupt and event transfer unit
package ietu_pkg;
    localparam int NODES     = 46;
    localparam int CHANS     = 8;
    localparam int DED_NODES = 38;
    localparam int GATE_NODE0 = 38;
    localparam int SHR_NODE0 = 42;
    localparam int SHR_N     = 4;
    localparam int RT_N      = 4;
    localparam int TRAP_N    = 4;
    localparam int AW        = 8;
    localparam int DW        = 16;
    localparam int PRIO_W    = 4;
    localparam int CNT_W     = 8;
    localparam int NODE_W    = 6;
    localparam int CH_W      = 3;
    localparam int IRQ_W     = 3;

    // register offsets (one register per address)
    localparam logic [AW-1:0] OFS_NODE0    = 8'h00;
    localparam logic [AW-1:0] OFS_NODE_END = 8'h2E;
    localparam logic [AW-1:0] OFS_CHAN0    = 8'h40;
    localparam logic [AW-1:0] OFS_CHAN_MSK = 8'hE0;
    localparam logic [AW-1:0] OFS_SRCSEL   = 8'h60;
    localparam logic [AW-1:0] OFS_EDGE     = 8'h61;
    localparam logic [AW-1:0] OFS_ROUTE    = 8'h62;
    localparam logic [AW-1:0] OFS_TRIG     = 8'h63;
    localparam logic [AW-1:0] OFS_GATE0    = 8'h64;
    localparam logic [AW-1:0] OFS_GATE_MSK = 8'hFC;
    localparam logic [AW-1:0] OFS_IRQ_ST   = 8'h70;
    localparam logic [AW-1:0] OFS_IRQ_MSK  = 8'h71;

    // channel register fields within a channel's group of four
    localparam logic [1:0] CF_SRC  = 2'h0;
    localparam logic [1:0] CF_DST  = 2'h1;
    localparam logic [1:0] CF_CNT  = 2'h2;
    localparam logic [1:0] CF_CTL  = 2'h3;

    // node control fields
    localparam int NC_PRIO_LSB = 0;
    localparam int NC_EN       = 6;
    localparam int NC_REQ      = 7;
    localparam int NC_CH_LSB   = 8;
    localparam int NC_USE      = 11;
    // channel control fields
    localparam int CC_INC_DST  = 0;
    localparam int CC_INC_SRC  = 1;
    localparam int CC_WORD     = 2;
    localparam int CC_CONT     = 3;
    // edge config: input select above the mode pairs
    localparam int EDGE_SEL_LSB = 8;
    // gate config: mode above the pattern
    localparam int GC_MODE_LSB  = 4;
    // interrupt status bits
    localparam int IRQ_TRAP  = 0;
    localparam int IRQ_CZERO = 1;
    localparam int IRQ_GATE  = 2;

    localparam logic [DW-1:0] RST_WORD      = 16'h0000;
    localparam logic [DW-1:0] BYTE_STEP     = 16'h0001;
    localparam logic [DW-1:0] WORD_STEP     = 16'h0002;
    localparam logic [DW-1:0] TRAP_VEC_BASE = 16'h0000;
    localparam logic [DW-1:0] NODE_VEC_BASE = 16'h0040;
    localparam int            VEC_SHIFT     = 2;

    // service latency in cpu clocks, request pulse to entry pulse
    localparam logic [3:0] LAT_HIT  = 4'h7;
    localparam logic [3:0] LAT_MISS = 4'hB;
    localparam logic [3:0] LAT_ADJ  = 4'h3;

    typedef enum logic [1:0] {
        EDGE_OFF  = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } ietu_edge_e;

    typedef enum logic [1:0] {
        GATE_OFF   = 2'b00,
        GATE_ALL   = 2'b01,
        GATE_MATCH = 2'b10,
        GATE_MISS  = 2'b11
    } ietu_gate_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } ietu_state_e;
endpackage : ietu_pkg

// >>> ietu_edge_chan.sv
// one edge trigger channel of the request routing unit
`timescale 1ns/100ps
module ietu_edge_chan
    import ietu_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       level,
    input  wire logic [1:0] mode,
    output logic            event_pulse
);
    logic prev_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level;
        end
    end

    assign event_pulse = (mode[0] & level & ~prev_reg) | (mode[1] & ~level & prev_reg);
endmodule : ietu_edge_chan

// >>> ietu_core_monitor.sv
// concurrent checks on the ports of the interrupt and event transfer unit
`timescale 1ns/100ps
module ietu_core_monitor
    import ietu_pkg::*;
(
    input wire logic          clk,
    input wire logic          arst_n,
    input wire logic          reg_rd,
    input wire logic [DW-1:0] reg_rdata,
    input wire logic          cpu_entry,
    input wire logic [DW-1:0] entry_vector,
    input wire logic          entry_is_trap,
    input wire logic          xfer_req,
    input wire logic [DW-1:0] xfer_src,
    input wire logic [DW-1:0] xfer_dst
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // at least six cycles from one entry to the next
    sequence s_no_entry5;
        !cpu_entry [*5];
    endsequence

    a_entry_spacing: assert property (cpu_entry |=> s_no_entry5)
        else $error("entries closer than six cycles");
    a_entry_xfer_excl: assert property (!(cpu_entry && xfer_req))
        else $error("entry and transfer in one cycle");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read answer");
    a_vector_align: assert property (cpu_entry |-> entry_vector[1:0] == 2'h0)
        else $error("entry vector not on a four step");
    a_trap_vector: assert property (cpu_entry && entry_is_trap |-> entry_vector < 16'h0010)
        else $error("trap vector outside trap table");
    a_node_vector: assert property (cpu_entry && !entry_is_trap
        |-> entry_vector >= 16'h0040 && entry_vector <= 16'h00F4)
        else $error("node vector outside node table");
    a_vector_held: assert property (cpu_entry |-> $stable(entry_vector))
        else $error("vector moved in the entry cycle");
    a_ptr_held: assert property (!xfer_req |-> $stable(xfer_src) && $stable(xfer_dst))
        else $error("pointers moved without a transfer");
endmodule : ietu_core_monitor

// >>> ietu_cpu_model.sv
// cpu side model: level, jump cache answer and counts of services
`timescale 1ns/100ps
module ietu_cpu_model
    import ietu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              want_hit,
    input  wire logic [PRIO_W-1:0] want_level,
    input  wire logic              cpu_entry,
    input  wire logic              xfer_req,
    output logic      [PRIO_W-1:0] cpu_level,
    output logic                   jump_cache_hit,
    output int                     n_entry,
    output int                     n_xfer
);
    // cache answer and level follow the bench's wish one cycle late
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_level      <= '0;
            jump_cache_hit <= 1'b1;
            n_entry        <= 0;
            n_xfer         <= 0;
        end else begin
            cpu_level      <= want_level;
            jump_cache_hit <= want_hit;
            n_entry        <= n_entry + int'(cpu_entry);
            n_xfer         <= n_xfer + int'(xfer_req);
        end
    end
endmodule : ietu_cpu_model

// >>> tb.sv
// self-checking bench for the interrupt and event transfer unit
`timescale 1ns/100ps
module tb;
    import ietu_pkg::*;
    logic clk, arst_n, reg_wr, reg_rd, want_hit, cpu_entry, entry_is_trap, xfer_req, xfer_word;
    logic jump_cache_hit, irq;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata, reg_rdata, entry_vector, xfer_src, xfer_dst;
    logic [DED_NODES-1:0] periph_req;
    logic [2*SHR_N-1:0] shared_req;
    logic [RT_N-1:0] ext_pin, rt_periph;
    logic [TRAP_N-1:0] trap_req;
    logic [PRIO_W-1:0] cpu_level, want_level;
    logic [CH_W-1:0] xfer_chan;
    int errors, num_checks, n, n_entry, n_xfer;

    ietu_core u_ietu_core (.*);
    ietu_cpu_model u_ietu_cpu_model (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp, "read data");
    endtask : rd

    task automatic pulse(input logic [37:0] p, input logic [3:0] t, input logic [7:0] s);
        @(posedge clk);
        periph_req <= p;
        trap_req   <= t;
        shared_req <= s;
        @(posedge clk);
        periph_req <= '0;
        trap_req   <= '0;
        shared_req <= '0;
    endtask : pulse

    // n counts cycles with the source pulse cycle as zero
    task automatic wait_for(input logic want_x);
        n = 1;
        do begin
            @(posedge clk);
            #1 n++;
            if (n > 40) begin
                errors++;
                $display("[FAIL] %0t no service seen", $time);
                tally_and_finish();
            end
        end while (want_x ? xfer_req !== 1'b1 : cpu_entry !== 1'b1);
    endtask : wait_for

    task automatic serve(input logic [37:0] p, input logic [3:0] t, input logic [7:0] s,
                         input logic [DW-1:0] vec, input logic trap, input int lat);
        pulse(p, t, s);
        wait_for(1'b0);
        if (lat > 0) chk(16'(n), 16'(lat), "entry latency");
        chk(entry_vector, vec, "entry vector");
        chk({15'h0, entry_is_trap}, {15'h0, trap}, "trap flag");
    endtask : serve

    task automatic xfer(input logic [37:0] p, input logic [DW-1:0] s, input logic [DW-1:0] d,
                        input logic w, input logic [2:0] c);
        pulse(p, 4'h0, 8'h00);
        wait_for(1'b1);
        chk(16'(n), 16'h0002, "transfer latency");
        chk(xfer_src, s, "source pointer");
        chk(xfer_dst, d, "destination pointer");
        chk({12'h0, xfer_word, xfer_chan}, {12'h0, w, c}, "width and channel");
    endtask : xfer

    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, periph_req, shared_req} = '0;
        {ext_pin, rt_periph, trap_req, want_level} = '0;
        want_hit = 1'b1;
        arst_n = 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h3F, 16'h0000);
        rd(8'h05, 16'h0000);
        wr(8'h05, 16'h0043);
        serve(38'h20, 4'h0, 8'h00, 16'h0054, 1'b0, 7);
        rd(8'h05, 16'h0043);
        want_hit <= 1'b0;
        serve(38'h20, 4'h0, 8'h00, 16'h0054, 1'b0, 11);
        want_hit <= 1'b1;
        $display("test standard entry done");
        wr(8'h06, 16'h0042);
        wr(8'h07, 16'h0044);
        serve(38'hC0, 4'h0, 8'h00, 16'h005C, 1'b0, 7);
        wait_for(1'b0);
        chk(entry_vector, 16'h0058, "second winner");
        $display("test priority done");
        serve(38'h0, 4'h4, 8'h00, 16'h0008, 1'b1, 7);
        $display("test trap done");
        wr(8'h60, 16'h0001);
        wr(8'h2A, 16'h0041);
        want_level <= 4'h1;
        pulse(38'h0, 4'h0, 8'h02);
        rd(8'h2A, 16'h00C1);
        wr(8'h2A, 16'h0041);
        want_level <= 4'h0;
        serve(38'h0, 4'h0, 8'h02, 16'h00E8, 1'b0, 7);
        $display("test shared node done");
        wr(8'h61, 16'h0101);
        wr(8'h62, 16'h0001);
        wr(8'h64, 16'h0010);
        wr(8'h26, 16'h0041);
        @(posedge clk);
        rt_periph <= 4'h1;
        wait_for(1'b0);
        chk(entry_vector, 16'h00D8, "gate node vector");
        rd(8'h63, 16'h0001);
        $display("test routing done");
        wr(8'h61, 16'h010D);
        wr(8'h62, 16'h0021);
        wr(8'h65, 16'h0032);
        wr(8'h27, 16'h0041);
        ext_pin <= 4'h2;
        wait_for(1'b0);
        chk(entry_vector, 16'h00DC, "gate miss");
        wr(8'h65, 16'h0022);
        ext_pin <= 4'h0;
        wait_for(1'b0);
        chk(entry_vector, 16'h00DC, "gate match");
        $display("test pin gating done");
        wr(8'h70, 16'h0007);
        wr(8'h48, 16'h1000);
        wr(8'h49, 16'h2000);
        wr(8'h4A, 16'h0002);
        wr(8'h4B, 16'h0007);
        wr(8'h0A, 16'h0A41);
        xfer(38'h400, 16'h1000, 16'h2000, 1'b1, 3'h2);
        xfer(38'h400, 16'h1002, 16'h2002, 1'b1, 3'h2);
        rd(8'h4A, 16'h0000);
        rd(8'h48, 16'h1004);
        serve(38'h400, 4'h0, 8'h00, 16'h0068, 1'b0, 7);
        rd(8'h70, 16'h0002);
        chk({15'h0, irq}, 16'h0000, "irq masked");
        wr(8'h71, 16'h0002);
        #1 chk({15'h0, irq}, 16'h0001, "irq raised");
        wr(8'h70, 16'h0002);
        #1 chk({15'h0, irq}, 16'h0000, "irq cleared");
        $display("test counted transfer done");
        wr(8'h5C, 16'h0300);
        wr(8'h5D, 16'h0400);
        wr(8'h5E, 16'h0005);
        wr(8'h5F, 16'h000A);
        wr(8'h0B, 16'h0F41);
        xfer(38'h800, 16'h0300, 16'h0400, 1'b0, 3'h7);
        xfer(38'h800, 16'h0301, 16'h0400, 1'b0, 3'h7);
        rd(8'h5E, 16'h0005);
        $display("test continuous transfer done");
        chk(16'(n_entry), 16'h000A, "entry count");
        chk(16'(n_xfer), 16'h0004, "transfer count");
        tally_and_finish();
    end
endmodule : tb

bind ietu_core ietu_core_monitor u_ietu_core_monitor (.clk, .arst_n, .reg_rd, .reg_rdata,
    .cpu_entry, .entry_vector, .entry_is_trap, .xfer_req, .xfer_src, .xfer_dst);
